// ==== hw/alarm_sup_pkg.sv ====
// Constants, alarm indices and state encodings of the alarm supervisor.
// Assumes a 125 MHz clock; module link status arrives already on this clock.
// How it works
// RULE1: Disconnected sensor over five seconds raises wire fault.
// RULE2: Damaged, broken or wrong sensor raises wire fault.
// RULE3: Misplaced sensor raises constellation alarm with position.
// RULE4: Missing, extra or wrong module raises link alarm.
// RULE5: Unsupported module link version raises compatibility alarm.
// RULE6: Absent or corrupt configuration raises missing alarm.
// RULE7: Light over ten seconds raises faulty detection.
// RULE8: Excess internal temperature raises overheat alarm.
// RULE9: List holds hundred entries; full raises overflow.
// RULE10: Overflow acknowledged only after all others.
// RULE11: Shorted sensor input raises short circuit alarm.
// RULE12: Interrupted parameter transfer raises parameterization alarm.
// RULE13: Reported hardware faults raise watchdog, converter alarms.
// RULE14: Failed non-volatile access raises flash alarm.
// RULE15: Button held at power-up runs configuration.
// RULE16: Alarm leaves only when acknowledged and inactive.
// RULE17: Active alarms saved and restored across supply loss.
// RULE18: Any active system error drives supervision relay.
// RULE19: Ack only with source inactive; relay then releases.
// RULE20: Full list keeps entries, records nothing new.
package alarm_sup_pkg;
  localparam int N_KIND = 14;
  localparam int K_FLASH = 0;
  localparam int K_PARAM = 1;
  localparam int K_WDOG = 2;
  localparam int K_CONV_IN = 3;
  localparam int K_CONV_OUT = 4;
  localparam int K_WIRE = 5;
  localparam int K_SCONST = 6;
  localparam int K_LCONST = 7;
  localparam int K_COMPAT = 8;
  localparam int K_CFG = 9;
  localparam int K_LIGHT = 10;
  localparam int K_HEAT = 11;
  localparam int K_OVF = 12;
  localparam int K_SHORT = 13;
  // Event numbers shown to the operator, indexed by alarm kind.
  localparam logic [N_KIND-1:0][5:0] EVENT_CODE = '{
    6'h37, 6'h35, 6'h30, 6'h2f, 6'h17, 6'h16, 6'h15, 6'h13, 6'h12, 6'h10, 6'h0f, 6'h0e, 6'h09, 6'h06};
  localparam int LIST_DEPTH = 100;
  localparam int ENTRY_W = 16;
  localparam longint CLK_HZ = 125000000;
  localparam longint WIRE_TIME_MS = 5000;
  localparam longint LIGHT_TIME_MS = 10000;
  localparam longint WIRE_CYC = WIRE_TIME_MS * CLK_HZ / 1000;
  localparam longint LIGHT_CYC = LIGHT_TIME_MS * CLK_HZ / 1000;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [N_KIND-1:0] ACTIVE_RST = 14'h0000;
  typedef enum logic [2:0] {M_BOOT, M_CFG_MOD, M_CFG_SEN, M_STORE, M_RUN} mode_t;
endpackage : alarm_sup_pkg

// ==== hw/alarm_list_mem.sv ====
// Alarm list storage: one write port, one read port with registered data.
// Assumes writes and reads come from logic on the same clock.
`timescale 1ns/1ps
module alarm_list_mem #(
  parameter int W = 16,
  parameter int DEPTH = 100,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_clk,
  input wire logic i_wr_en,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [W-1:0] i_wr_data,
  input wire logic [AW-1:0] i_rd_addr,
  output logic [W-1:0] o_rd_data
);
  logic [W-1:0] mem [DEPTH];

  if (DEPTH < 1 || W < 1 || AW < $clog2(DEPTH)) begin : g_chk
    $error("alarm_list_mem: depth, width or address width out of range");
  end

  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem[i_wr_addr] <= i_wr_data;
    end
    o_rd_data <= mem[i_rd_addr];
  end
endmodule : alarm_list_mem

// ==== hw/arc_alarm_supervisor.sv ====
// Alarm supervisor of the protection master: raises, logs and clears system alarms.
// Assumes fault flags and i_ack pulses come from logic on i_clk; only the button is a pin.
`timescale 1ns/1ps
module arc_alarm_supervisor #(
  parameter int N_CH = 3,
  parameter int CW = 31,
  parameter longint WIRE_CYC = alarm_sup_pkg::WIRE_CYC,
  parameter longint LIGHT_CYC = alarm_sup_pkg::LIGHT_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ack_button,
  input wire logic i_ack,
  input wire logic [3:0] i_ack_kind,
  input wire logic i_ack_all,
  input wire logic i_store_done,
  input wire logic [N_CH-1:0] i_sensor_open,
  input wire logic [N_CH-1:0] i_light_seen,
  input wire logic i_sensor_bad,
  input wire logic i_sensor_misplaced,
  input wire logic i_sensor_short,
  input wire logic i_module_missing,
  input wire logic i_module_unexpected,
  input wire logic i_module_wrong_type,
  input wire logic i_version_bad,
  input wire logic i_cfg_missing,
  input wire logic i_overheat,
  input wire logic i_flash_err,
  input wire logic i_param_xfer_err,
  input wire logic i_wd_reset_flag,
  input wire logic i_conv_in_err,
  input wire logic i_conv_out_err,
  input wire logic [4:0] i_src_module,
  input wire logic [4:0] i_src_sensor,
  input wire logic i_nv_restore,
  input wire logic [alarm_sup_pkg::N_KIND-1:0] i_nv_alarms,
  input wire logic [6:0] i_list_rd_addr,
  output logic [alarm_sup_pkg::N_KIND-1:0] o_alarms,
  output logic o_supervision_relay,
  output logic o_config_mode,
  output logic o_cfg_sensor_step,
  output logic o_cfg_store,
  output logic o_restart,
  output logic [6:0] o_list_count,
  output logic [alarm_sup_pkg::ENTRY_W-1:0] o_list_rd_data
);
  localparam int NK = alarm_sup_pkg::N_KIND;
  localparam logic [CW-1:0] WIRE_LIM = CW'(WIRE_CYC);
  localparam logic [CW-1:0] LIGHT_LIM = CW'(LIGHT_CYC);
  localparam logic [NK-1:0] OVF_BIT = NK'(1) << alarm_sup_pkg::K_OVF;
  localparam logic [6:0] FULL = 7'(alarm_sup_pkg::LIST_DEPTH);

  if (N_CH < 1 || N_CH > 32 || CW < 8 || WIRE_CYC >= (64'h1 << CW) - 1 || LIGHT_CYC >= (64'h1 << CW) - 1) begin : g_chk
    $error("arc_alarm_supervisor: channel count or counter width out of range");
  end

  typedef struct packed {
    alarm_sup_pkg::mode_t mode;
    logic [1:0] boot_cnt;
    logic btn_s1;
    logic btn_s2;
    logic [NK-1:0] active;
    logic [NK-1:0] log_pend;
    logic [6:0] count;
    logic [N_CH-1:0][CW-1:0] wire_cnt;
    logic [N_CH-1:0][CW-1:0] light_cnt;
    logic cfg_store;
    logic restart;
  } state_t;

  state_t st;
  state_t next;
  logic [N_CH-1:0] wire_exp;
  logic [N_CH-1:0] light_exp;
  logic [NK-1:0] cond;
  logic [NK-1:0] ok_mask;
  logic [NK-1:0] clear_mask;
  logic [NK-1:0] pend;
  logic full;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [alarm_sup_pkg::ENTRY_W-1:0] wr_data;
  logic [3:0] pick;

  // Lowest set bit of a pending vector.
  function automatic logic [3:0] first_set(input logic [NK-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = NK - 1; k >= 0; k--) begin
      if (v[k]) begin
        r = 4'(k);
      end
    end
    return r;
  endfunction : first_set

  for (genvar c = 0; c < N_CH; c++) begin : g_ch
    assign wire_exp[c] = st.wire_cnt[c] > WIRE_LIM; // RULE1
    assign light_exp[c] = st.light_cnt[c] > LIGHT_LIM; // RULE7
  end

  assign full = st.count == FULL;

  always_comb begin
    cond = '0;
    if (st.mode == alarm_sup_pkg::M_RUN) begin
      cond[alarm_sup_pkg::K_FLASH] = i_flash_err; // RULE14
      cond[alarm_sup_pkg::K_PARAM] = i_param_xfer_err; // RULE12
      cond[alarm_sup_pkg::K_WDOG] = i_wd_reset_flag; // RULE13
      cond[alarm_sup_pkg::K_CONV_IN] = i_conv_in_err; // RULE13
      cond[alarm_sup_pkg::K_CONV_OUT] = i_conv_out_err; // RULE13
      cond[alarm_sup_pkg::K_WIRE] = (|wire_exp) | i_sensor_bad; // RULE1 RULE2
      cond[alarm_sup_pkg::K_SCONST] = i_sensor_misplaced; // RULE3
      cond[alarm_sup_pkg::K_LCONST] = i_module_missing | i_module_unexpected | i_module_wrong_type; // RULE4
      cond[alarm_sup_pkg::K_COMPAT] = i_version_bad; // RULE5
      cond[alarm_sup_pkg::K_CFG] = i_cfg_missing; // RULE6
      cond[alarm_sup_pkg::K_LIGHT] = |light_exp; // RULE7
      cond[alarm_sup_pkg::K_HEAT] = i_overheat; // RULE8
      cond[alarm_sup_pkg::K_SHORT] = i_sensor_short; // RULE11
      // Overflow is raised by a refused entry and stays sourced while the list is full.
      cond[alarm_sup_pkg::K_OVF] = full & (st.active[alarm_sup_pkg::K_OVF] | (|st.log_pend)
          | (|(cond & ~st.active & ~OVF_BIT))); // RULE9
    end
  end

  always_comb begin
    next = st;
    next.cfg_store = 1'b0;
    next.restart = 1'b0;
    next.btn_s1 = i_ack_button;
    next.btn_s2 = st.btn_s1;
    ok_mask = '0;
    clear_mask = '0;
    pend = '0;
    pick = 4'h0;
    wr_en = 1'b0;
    wr_addr = st.count;
    wr_data = '0;
    case (st.mode)
      alarm_sup_pkg::M_BOOT: begin
        if (st.boot_cnt == alarm_sup_pkg::BOOT_WAIT) begin
          next.mode = st.btn_s2 ? alarm_sup_pkg::M_CFG_MOD : alarm_sup_pkg::M_RUN; // RULE15
        end else begin
          next.boot_cnt = st.boot_cnt + 2'h1;
        end
      end
      alarm_sup_pkg::M_CFG_MOD: begin
        if (i_ack) begin
          next.mode = alarm_sup_pkg::M_CFG_SEN; // RULE15
        end
      end
      alarm_sup_pkg::M_CFG_SEN: begin
        if (i_ack) begin
          next.mode = alarm_sup_pkg::M_STORE; // RULE15
          next.cfg_store = 1'b1;
        end
      end
      alarm_sup_pkg::M_STORE: begin
        if (i_store_done) begin
          next.restart = 1'b1; // RULE15
          next.mode = alarm_sup_pkg::M_BOOT;
          next.boot_cnt = 2'h0;
        end
      end
      alarm_sup_pkg::M_RUN: begin
        for (int c = 0; c < N_CH; c++) begin
          next.wire_cnt[c] = !i_sensor_open[c] ? '0 : (wire_exp[c] ? st.wire_cnt[c] : st.wire_cnt[c] + 1'b1); // RULE1
          next.light_cnt[c] = !i_light_seen[c] ? '0 : (light_exp[c] ? st.light_cnt[c] : st.light_cnt[c] + 1'b1); // RULE7
        end
        // Overflow waits until every other alarm is gone; the rest need an inactive source.
        ok_mask = ~cond & ~((|(st.active & ~OVF_BIT)) ? OVF_BIT : '0); // RULE10 RULE19
        if (i_ack_all) begin
          clear_mask = ok_mask;
        end else if (i_ack) begin
          clear_mask = (NK'(1) << i_ack_kind) & ok_mask;
        end
        // A raise in the same cycle as its acknowledge wins.
        next.active = (st.active & ~clear_mask) | cond | (i_nv_restore ? i_nv_alarms : '0); // RULE16 RULE17 RULE18
        pend = (st.log_pend | (cond & ~st.active)) & ~OVF_BIT;
        if (|pend) begin
          pick = first_set(pend);
          pend[pick] = 1'b0;
          if (!full) begin
            wr_en = 1'b1; // RULE9
            wr_data = {alarm_sup_pkg::EVENT_CODE[pick], i_src_module, i_src_sensor}; // RULE3
            next.count = st.count + 7'h1;
          end
        end
        next.log_pend = pend; // RULE20
        if (~|(next.active & ~OVF_BIT)) begin
          next.count = 7'h0;
        end
      end
      default: begin
        next.mode = alarm_sup_pkg::M_BOOT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '{mode: alarm_sup_pkg::M_BOOT, active: alarm_sup_pkg::ACTIVE_RST, default: '0};
    end else begin
      st <= next;
    end
  end

  alarm_list_mem #(.W(alarm_sup_pkg::ENTRY_W), .DEPTH(alarm_sup_pkg::LIST_DEPTH), .AW(7)) u_list (
    .i_clk(i_clk),
    .i_wr_en(wr_en),
    .i_wr_addr(wr_addr),
    .i_wr_data(wr_data),
    .i_rd_addr(i_list_rd_addr),
    .o_rd_data(o_list_rd_data)
  );

  assign o_alarms = st.active;
  assign o_supervision_relay = |st.active;
  assign o_config_mode = st.mode == alarm_sup_pkg::M_CFG_MOD || st.mode == alarm_sup_pkg::M_CFG_SEN;
  assign o_cfg_sensor_step = st.mode == alarm_sup_pkg::M_CFG_SEN;
  assign o_cfg_store = st.cfg_store;
  assign o_restart = st.restart;
  assign o_list_count = st.count;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence confirm_counts_s;
    st.mode == alarm_sup_pkg::M_CFG_SEN && i_ack;
  endsequence
  sequence store_pulse_s;
    o_cfg_store && st.mode == alarm_sup_pkg::M_STORE;
  endsequence
  sequence store_done_s;
    st.mode == alarm_sup_pkg::M_STORE && i_store_done;
  endsequence
  sequence restart_pulse_s;
    o_restart && st.mode == alarm_sup_pkg::M_BOOT && st.boot_cnt == 2'h0;
  endsequence

  raise_on_cond_a: assert property ((|(cond & ~st.active)) |=> (st.active & $past(cond)) == $past(cond)) // RULE8
    else $error("raised condition not latched");
  wire_timer_clear_a: assert property (st.mode == alarm_sup_pkg::M_RUN && !i_sensor_open[0] |=> st.wire_cnt[0] == '0) // RULE1
    else $error("wire timer not cleared");
  light_timer_run_a: assert property (st.mode == alarm_sup_pkg::M_RUN && i_light_seen[0] && !light_exp[0] // RULE7
      |=> st.light_cnt[0] == $past(st.light_cnt[0]) + 1'b1)
    else $error("light timer stalled");
  ovf_ack_order_a: assert property (st.active[alarm_sup_pkg::K_OVF] && (|(st.active & ~OVF_BIT)) // RULE10
      && (i_ack_all || (i_ack && i_ack_kind == 4'(alarm_sup_pkg::K_OVF))) |=> st.active[alarm_sup_pkg::K_OVF])
    else $error("overflow cleared before others");
  ack_refused_a: assert property (i_ack && cond[i_ack_kind] |=> st.active[$past(i_ack_kind)]) // RULE19
    else $error("ack accepted with active source");
  ack_removes_a: assert property (st.mode == alarm_sup_pkg::M_RUN && i_ack && !i_ack_all && !i_nv_restore // RULE16
      && i_ack_kind != 4'(alarm_sup_pkg::K_OVF) && !cond[i_ack_kind] |=> !st.active[$past(i_ack_kind)])
    else $error("acknowledged idle alarm kept");
  relay_release_a: assert property ($fell(o_supervision_relay) |-> $past(i_ack || i_ack_all)) // RULE19
    else $error("relay released without ack");
  list_bound_a: assert property (st.count <= FULL) // RULE9
    else $error("list count above depth");
  full_hold_a: assert property (full && (|(cond & ~st.active & ~OVF_BIT)) // RULE20
      |-> !wr_en ##1 st.active[alarm_sup_pkg::K_OVF])
    else $error("full list written or overflow not raised");
  config_store_a: assert property (confirm_counts_s |=> store_pulse_s) // RULE15
    else $error("configuration not stored after confirm");
  restart_after_store_a: assert property (store_done_s |=> restart_pulse_s) // RULE15
    else $error("no restart after configuration store");
endmodule : arc_alarm_supervisor

// ==== verification/module_link_model.sv ====
// Behavioural light detection modules on the module link: turns bench fault requests into status levels.
// Assumes the bench changes its requests at the falling clock edge; levels follow at once.
`timescale 1ns/1ps
module module_link_model (
  input wire logic [13:0] i_req,
  input wire logic [1:0] i_sel,
  input wire logic [2:0] i_open,
  input wire logic [2:0] i_light,
  output logic [2:0] o_sensor_open,
  output logic [2:0] o_light_seen,
  output logic o_sensor_bad,
  output logic o_sensor_misplaced,
  output logic o_sensor_short,
  output logic o_module_missing,
  output logic o_module_unexpected,
  output logic o_module_wrong_type,
  output logic o_version_bad,
  output logic o_param_xfer_err,
  output logic o_wd_reset_flag,
  output logic o_conv_in_err,
  output logic o_conv_out_err
);
  assign o_sensor_open = i_open;
  assign o_light_seen = i_light;
  assign o_sensor_bad = i_req[5];
  assign o_sensor_misplaced = i_req[6];
  assign o_sensor_short = i_req[13];
  // One constellation fault flavour at a time, picked by the bench.
  assign o_module_missing = i_req[7] && i_sel == 2'h0;
  assign o_module_unexpected = i_req[7] && i_sel == 2'h1;
  assign o_module_wrong_type = i_req[7] && i_sel == 2'h2;
  assign o_version_bad = i_req[8];
  assign o_param_xfer_err = i_req[1];
  assign o_wd_reset_flag = i_req[2];
  assign o_conv_in_err = i_req[3];
  assign o_conv_out_err = i_req[4];
endmodule : module_link_model

// ==== verification/tb.sv ====
// Self-checking bench of the alarm supervisor with short sensor and light timers.
// Assumes the module link model beside it; inputs change at the falling edge.
`timescale 1ns/1ps
module tb;
  logic i_clk, i_resetn = 0, i_ack_button = 0, i_ack = 0, i_ack_all = 0, i_store_done = 0, i_nv_restore = 0;
  logic [3:0] i_ack_kind = 4'h0;
  logic [13:0] req = 14'h0, i_nv_alarms = 14'h0, o_alarms;
  logic [1:0] sel = 2'h0;
  logic [2:0] opn = 3'h0, lit = 3'h0, s_open, s_light;
  logic s_bad, s_mis, s_short, m_miss, m_unexp, m_wrong, v_bad, p_err, wd, c_in, c_out;
  logic [4:0] i_src_module = 5'h0, i_src_sensor = 5'h0;
  logic [6:0] i_list_rd_addr = 7'h0, o_list_count;
  logic [15:0] o_list_rd_data;
  logic o_supervision_relay, o_config_mode, o_cfg_sensor_step, o_cfg_store, o_restart;
  int n_fail = 0, check_count = 0, seed = 32'h2331, k, t, seen;
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  module_link_model u_link (.i_req(req), .i_sel(sel), .i_open(opn), .i_light(lit), .o_sensor_open(s_open),
    .o_light_seen(s_light), .o_sensor_bad(s_bad), .o_sensor_misplaced(s_mis), .o_sensor_short(s_short),
    .o_module_missing(m_miss), .o_module_unexpected(m_unexp), .o_module_wrong_type(m_wrong),
    .o_version_bad(v_bad), .o_param_xfer_err(p_err), .o_wd_reset_flag(wd), .o_conv_in_err(c_in),
    .o_conv_out_err(c_out));
  arc_alarm_supervisor #(.N_CH(3), .WIRE_CYC(20), .LIGHT_CYC(40)) u_dut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_ack_button(i_ack_button), .i_ack(i_ack), .i_ack_kind(i_ack_kind), .i_ack_all(i_ack_all),
    .i_store_done(i_store_done), .i_sensor_open(s_open), .i_light_seen(s_light), .i_sensor_bad(s_bad),
    .i_sensor_misplaced(s_mis), .i_sensor_short(s_short), .i_module_missing(m_miss),
    .i_module_unexpected(m_unexp), .i_module_wrong_type(m_wrong), .i_version_bad(v_bad),
    .i_cfg_missing(req[9]), .i_overheat(req[11]), .i_flash_err(req[0]), .i_param_xfer_err(p_err),
    .i_wd_reset_flag(wd), .i_conv_in_err(c_in), .i_conv_out_err(c_out), .i_src_module(i_src_module),
    .i_src_sensor(i_src_sensor), .i_nv_restore(i_nv_restore), .i_nv_alarms(i_nv_alarms),
    .i_list_rd_addr(i_list_rd_addr), .o_alarms(o_alarms), .o_supervision_relay(o_supervision_relay),
    .o_config_mode(o_config_mode), .o_cfg_sensor_step(o_cfg_sensor_step), .o_cfg_store(o_cfg_store),
    .o_restart(o_restart), .o_list_count(o_list_count), .o_list_rd_data(o_list_rd_data));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask : cyc
  task automatic ack(input int kd);
    @(negedge i_clk);
    i_ack = 1;
    i_ack_kind = kd[3:0];
    @(negedge i_clk);
    i_ack = 0;
  endtask : ack
  task automatic do_reset(input logic btn);
    @(negedge i_clk);
    i_resetn = 0;
    i_ack_button = btn;
    cyc(12);
    chk(o_alarms, 0);
    i_resetn = 1;
    cyc(8);
  endtask : do_reset
  // Counts the cycles in which the chosen one-cycle pulse is seen high.
  task automatic see_pulse(input bit rst_pulse, output int hit);
    hit = 0;
    repeat (6) begin
      if ((rst_pulse ? o_restart : o_cfg_store) === 1'b1) hit++;
      @(negedge i_clk);
    end
  endtask : see_pulse
  task automatic print_verdict;
    if (n_fail == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    cyc(20000);
    n_fail++;
    print_verdict();
  end
  initial begin
    do_reset(0);
    chk(o_config_mode, 0);
    for (k = 0; k < 14; k++) begin
      if (k == 10 || k == 12) continue;
      sel = 2'($unsigned($random(seed)) % 3);
      req[k] = 1;
      cyc(2);
      chk(o_alarms, 32'h1 << k);
      chk(o_supervision_relay, 1);
      ack(k);
      cyc(1);
      chk(o_alarms[k], 1);
      req[k] = 0;
      ack(k);
      cyc(1);
      chk(o_alarms, 0);
      chk(o_supervision_relay, 0);
    end
    for (t = 0; t < 2; t++) begin
      k = $unsigned($random(seed)) % 3;
      if (t == 0) opn[k] = 1;
      else lit[k] = 1;
      cyc(t ? 40 : 20);
      chk(o_alarms, 0);
      cyc(6);
      chk(o_alarms, t ? 32'h400 : 32'h20);
      opn = 0;
      lit = 0;
      ack(t ? 10 : 5);
    end
    cyc(1);
    chk(o_list_count, 0);
    i_src_module = 5'($random(seed));
    i_src_sensor = 5'($random(seed));
    req[0] = 1;
    cyc(2);
    for (k = 0; k < 100; k++) begin
      req[11] = 1;
      cyc(2);
      if (k == 98) chk({o_alarms[12], o_list_count}, 8'h64);
      if (k < 99) req[11] = 0;
      if (k < 99) ack(11);
    end
    chk({o_alarms[12], o_list_count}, 8'he4);
    ack(12);
    cyc(1);
    chk(o_alarms, 14'h1801);
    i_list_rd_addr = 7'h0;
    cyc(2);
    chk(o_list_rd_data, {alarm_sup_pkg::EVENT_CODE[alarm_sup_pkg::K_FLASH], i_src_module, i_src_sensor});
    req = 0;
    ack(0);
    ack(11);
    ack(12);
    cyc(1);
    chk({o_alarms, o_list_count}, 0);
    i_nv_alarms = 14'($random(seed)) & 14'h2fff | 14'h1;
    i_nv_restore = 1;
    cyc(1);
    i_nv_restore = 0;
    cyc(1);
    chk(o_alarms, i_nv_alarms);
    i_ack_all = 1;
    cyc(1);
    i_ack_all = 0;
    cyc(1);
    chk({o_alarms, o_supervision_relay}, 0);
    do_reset(1);
    chk(o_config_mode, 1);
    i_ack_button = 0;
    ack(0);
    cyc(1);
    chk(o_cfg_sensor_step, 1);
    ack(0);
    see_pulse(0, seen);
    chk(seen, 1);
    @(negedge i_clk);
    i_store_done = 1;
    cyc(1);
    i_store_done = 0;
    see_pulse(1, seen);
    chk(seen, 1);
    cyc(8);
    chk(o_config_mode, 0);
    print_verdict();
  end
endmodule : tb
